// ### shared/ata_cmd_pkg.sv
/*
 Constants for the capacity-limit, multiple, power and monitoring command
 block: register byte offsets, opcodes, field positions, states.
 Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package ata_cmd_pkg;
    localparam int LBA_W = 28;
    // Register byte offsets
    localparam logic [5:0] OFS_FEAT = 6'h00;
    localparam logic [5:0] OFS_SCNT = 6'h04;
    localparam logic [5:0] OFS_SNUM = 6'h08;
    localparam logic [5:0] OFS_CYLL = 6'h0c;
    localparam logic [5:0] OFS_CYLH = 6'h10;
    localparam logic [5:0] OFS_DRVH = 6'h14;
    localparam logic [5:0] OFS_CMD = 6'h18;
    localparam logic [5:0] OFS_STAT = 6'h1c;
    localparam logic [5:0] OFS_ERR = 6'h20;
    localparam logic [5:0] OFS_MAX = 6'h24;
    localparam logic [5:0] OFS_MULT = 6'h28;
    localparam logic [5:0] OFS_REM = 6'h2c;
    localparam logic [5:0] OFS_IDW82 = 6'h30;
    // Opcodes
    localparam logic [7:0] OP_NATIVE = 8'hf8;
    localparam logic [7:0] OP_SETMAX = 8'hf9;
    localparam logic [7:0] OP_SETMULT = 8'hc6;
    localparam logic [7:0] OP_RDMULT = 8'hc4;
    localparam logic [7:0] OP_WRMULT = 8'hc5;
    localparam logic [7:0] OP_SLEEP_A = 8'h99;
    localparam logic [7:0] OP_SLEEP_B = 8'he6;
    localparam logic [7:0] OP_STBY_A = 8'h96;
    localparam logic [7:0] OP_STBY_B = 8'he2;
    localparam logic [7:0] OP_SMART = 8'hb0;
    // Capacity-limit subfunction codes
    localparam logic [7:0] FC_PASSWORD = 8'h01;
    localparam logic [7:0] FC_LOCK = 8'h02;
    localparam logic [7:0] FC_UNLOCK = 8'h03;
    localparam logic [7:0] FC_FREEZE = 8'h04;
    localparam logic [7:0] FC_OBSOLETE = 8'h00;
    // Monitoring command signature
    localparam logic [7:0] SMART_CYLH = 8'hc2;
    localparam logic [7:0] SMART_CYLL = 8'h4f;
    localparam logic [2:0] SMART_DH_TOP = 3'h7;
    // Field positions
    localparam int DH_LBA = 6;
    localparam int DH_DEV = 4;
    localparam int SC_KEEP = 0;
    localparam int SC_SUB = 1;
    localparam int SB_BUSY = 7;
    localparam int SB_READY = 6;
    localparam int SB_SLEEP = 5;
    localparam int SB_MULT = 4;
    localparam int SB_LOCK = 3;
    localparam int SB_FRZ = 2;
    localparam int SB_ERR = 0;
    localparam int EB_ABRT = 2;
    // Largest block size accepted by the set-multiple command
    localparam logic [7:0] MULT_MAX = 8'h10;
    localparam logic [8:0] SC_ZERO_TOTAL = 9'h100;
    // Identification word 82: bit 0 reports monitoring support
    localparam logic [15:0] IDW82_VAL = 16'h0001;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_XFER = 3'b100
    } state_t;
endpackage

// ### core/pin_sync.sv
/*
 Three-stage synchroniser for a pin input with agreement filter.
 Assumes an active-low reset already synchronised to clk.
*/
module pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Change is accepted once stages two and three agree
            if (s2_r == s3_r) begin
                q <= s3_r;
            end
        end
    end
endmodule

// ### core/ata_cmd_core.sv
/*
 Task-file command block: capacity limit, set multiple, sleep/standby,
 monitoring entry and multiple-transfer block sequencing.
 Assumes Avalon-MM master on clk, nonvolatile store on nv_max_*, and a
 data engine that takes block descriptors on blk_valid/blk_ready.
*/
// The address map and register access over Avalon-MM were chosen for this implementation.
// Overview of operation
// RULE1: Opcode F9h replaces the current max sector with the task-file LBA.
// RULE2: Host sets the LBA bit in drive/head for the capacity-limit command.
// RULE3: Device acts only when the device-select bit matches its own number.
// RULE4: Host issues F9h only when ready and right after a native-max read.
// RULE5: Keep bit set persists the maximum; clear reverts after reset.
// RULE6: Features 01h-04h: password, lock, unlock, freeze; others not valid.
// RULE7: A second nonvolatile limit after reset is aborted.
// RULE8: Firmware shutdown: volatile limit to native max, save, power off.
// RULE9: Firmware boot: limit to native, read config, limit to fs size.
// RULE10: Opcode C6h raises busy and examines the sector count.
// RULE11: Supported block size is stored and multiple commands enabled.
// RULE12: Unsupported block size aborts and disables multiple commands.
// RULE13: Block size zero disables multiple commands.
// RULE14: Multiple commands are disabled after power-on.
// RULE15: Opcode 99h or E6h enters sleep and completes at once.
// RULE16: Opcode 96h or E2h enters the same low-power state at once.
// RULE17: Any later command leaves the low-power state.
// RULE18: B0h needs C2h/4Fh cylinders and drive/head top bits all ones.
// RULE19: Identification word 82 bit 0 reports monitoring support.
// RULE20: Multiple transfer while disabled is aborted.
// RULE21: Uneven sector totals end with one partial block.
// RULE22: Obsolete or reserved subfunction aborts, maximum unchanged.
module ata_cmd_core #(
    parameter logic [27:0] NATIVE_MAX = 28'h0100000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dev_strap,
    input wire logic [27:0] nv_max_in,
    output logic [27:0] nv_max_out,
    output logic nv_max_we,
    output logic low_power,
    output logic completion_intrq,
    output logic blk_valid,
    input wire logic blk_ready,
    output logic [8:0] blk_len,
    output logic blk_is_write,
    output logic smart_req,
    output logic [7:0] smart_feature,
    output logic [7:0] smart_arg
);
    logic rst_s1_r;
    logic rst_n;
    logic ack_r;
    logic [7:0] feat_r, scnt_r, snum_r, cyll_r, cylh_r, drvh_r, cmd_r;
    logic err_r, sleep_r, mult_en_r, locked_r, frozen_r, nv_seen_r;
    logic init_done_r;
    logic [7:0] mult_r;
    logic [27:0] cur_max_r, pass_r;
    logic [8:0] rem_r;
    ata_cmd_pkg::state_t state_r, state_nxt;
    logic dev_sel;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    pin_sync u_strap (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(dev_strap),
        .q(dev_sel)
    );

    // Bus decode: one wait state on every access
    wire req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    wire rd_ack = avs_read & ack_r;
    wire wr_ack = avs_write & ack_r;
    wire a_feat = avs_address == ata_cmd_pkg::OFS_FEAT;
    wire a_scnt = avs_address == ata_cmd_pkg::OFS_SCNT;
    wire a_snum = avs_address == ata_cmd_pkg::OFS_SNUM;
    wire a_cyll = avs_address == ata_cmd_pkg::OFS_CYLL;
    wire a_cylh = avs_address == ata_cmd_pkg::OFS_CYLH;
    wire a_drvh = avs_address == ata_cmd_pkg::OFS_DRVH;
    wire a_cmd = avs_address == ata_cmd_pkg::OFS_CMD;
    wire a_stat = avs_address == ata_cmd_pkg::OFS_STAT;
    wire a_err = avs_address == ata_cmd_pkg::OFS_ERR;
    wire a_max = avs_address == ata_cmd_pkg::OFS_MAX;
    wire a_mult = avs_address == ata_cmd_pkg::OFS_MULT;
    wire a_rem = avs_address == ata_cmd_pkg::OFS_REM;
    wire a_idw = avs_address == ata_cmd_pkg::OFS_IDW82;

    wire busy_flag = state_r != ata_cmd_pkg::ST_IDLE;
    wire drive_ready_flag = init_done_r;
    wire device_select_bit = drvh_r[ata_cmd_pkg::DH_DEV];
    wire keep_over_reset_bit = scnt_r[ata_cmd_pkg::SC_KEEP];
    wire tf_wr = wr_ack & ~busy_flag;
    wire cmd_wr = wr_ack & a_cmd;
    wire dev_match = device_select_bit == dev_sel;
    wire cmd_take = cmd_wr & ~busy_flag & dev_match & init_done_r; // [RULE3]
    wire exec = state_r == ata_cmd_pkg::ST_EXEC;

    wire [7:0] status8 = {busy_flag, drive_ready_flag, sleep_r, mult_en_r,
                          locked_r, frozen_r, 1'b0, err_r};
    wire [7:0] error8 = {5'h00, err_r, 2'h0};
    wire [31:0] rd_mux =
        a_feat ? {24'h000000, feat_r} :
        a_scnt ? {24'h000000, scnt_r} :
        a_snum ? {24'h000000, snum_r} :
        a_cyll ? {24'h000000, cyll_r} :
        a_cylh ? {24'h000000, cylh_r} :
        a_drvh ? {24'h000000, drvh_r} :
        a_cmd ? {24'h000000, cmd_r} :
        a_stat ? {24'h000000, status8} :
        a_err ? {24'h000000, error8} :
        a_max ? {4'h0, cur_max_r} :
        a_mult ? {24'h000000, mult_r} :
        a_rem ? {23'h000000, rem_r} :
        a_idw ? {16'h0000, ata_cmd_pkg::IDW82_VAL} : // [RULE19]
        32'h00000000;

    // Command decode, evaluated during the execute cycle
    wire [27:0] lba = {drvh_r[3:0], cylh_r, cyll_r, snum_r};
    wire is_nat = cmd_r == ata_cmd_pkg::OP_NATIVE;
    wire is_setmax = cmd_r == ata_cmd_pkg::OP_SETMAX; // [RULE1]
    wire is_setmult = cmd_r == ata_cmd_pkg::OP_SETMULT; // [RULE10]
    wire is_rdm = cmd_r == ata_cmd_pkg::OP_RDMULT;
    wire is_wrm = cmd_r == ata_cmd_pkg::OP_WRMULT;
    wire is_sleep = (cmd_r == ata_cmd_pkg::OP_SLEEP_A) |
                    (cmd_r == ata_cmd_pkg::OP_SLEEP_B); // [RULE15]
    wire is_stby = (cmd_r == ata_cmd_pkg::OP_STBY_A) |
                   (cmd_r == ata_cmd_pkg::OP_STBY_B); // [RULE16]
    wire is_low = is_sleep | is_stby;
    wire is_smart = cmd_r == ata_cmd_pkg::OP_SMART;
    wire is_known = is_nat | is_setmax | is_setmult | is_rdm | is_wrm |
                    is_low | is_smart;

    wire [8:0] mult9 = {1'b0, mult_r};
    wire [8:0] sc_total = (scnt_r == 8'h00) ? ata_cmd_pkg::SC_ZERO_TOTAL :
                                              {1'b0, scnt_r};
    wire scnt_pow2 = (scnt_r & (scnt_r - 8'h01)) == 8'h00;
    wire mult_ok = (scnt_r != 8'h00) & scnt_pow2 &
                   (scnt_r <= ata_cmd_pkg::MULT_MAX);

    wire f9_plain = ~scnt_r[ata_cmd_pkg::SC_SUB];
    wire f9_code_bad = (feat_r == ata_cmd_pkg::FC_OBSOLETE) |
                       (feat_r > ata_cmd_pkg::FC_FREEZE); // [RULE22]
    wire f9_pw = feat_r == ata_cmd_pkg::FC_PASSWORD;
    wire f9_lock = feat_r == ata_cmd_pkg::FC_LOCK;
    wire f9_unlock = feat_r == ata_cmd_pkg::FC_UNLOCK;
    wire f9_freeze = feat_r == ata_cmd_pkg::FC_FREEZE;
    wire nv_again = keep_over_reset_bit & nv_seen_r; // [RULE7]
    wire f9_abort = f9_plain ?
        (locked_r | nv_again | (lba > NATIVE_MAX)) :
        (f9_code_bad | frozen_r | (f9_pw & locked_r) |
         (f9_unlock & (lba != pass_r))); // [RULE6]
    wire smart_ok = (cylh_r == ata_cmd_pkg::SMART_CYLH) &
                    (cyll_r == ata_cmd_pkg::SMART_CYLL) &
                    (drvh_r[7:5] == ata_cmd_pkg::SMART_DH_TOP); // [RULE18]
    wire abort_w = ~is_known | (is_setmax & f9_abort) |
                   (is_setmult & (scnt_r != 8'h00) & ~mult_ok) |
                   ((is_rdm | is_wrm) & ~mult_en_r) | // [RULE20]
                   (is_smart & ~smart_ok);
    wire setmax_go = exec & is_setmax & ~f9_abort;
    wire go_xfer = (is_rdm | is_wrm) & ~abort_w;

    // Block sequencing for multiple transfers
    wire hs = blk_valid & blk_ready;
    wire last_blk = rem_r == blk_len;
    wire [8:0] rem_left = rem_r - blk_len;
    wire [8:0] first_len = (sc_total < mult9) ? sc_total : mult9;
    wire [8:0] next_len = (rem_left < mult9) ? rem_left : mult9; // [RULE21]
    assign blk_valid = state_r == ata_cmd_pkg::ST_XFER;
    wire done_ev = (exec & ~go_xfer) | (hs & last_blk);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ata_cmd_pkg::ST_IDLE: begin
                if (cmd_take) begin
                    state_nxt = ata_cmd_pkg::ST_EXEC;
                end
            end
            ata_cmd_pkg::ST_EXEC: begin
                state_nxt = go_xfer ? ata_cmd_pkg::ST_XFER :
                                      ata_cmd_pkg::ST_IDLE;
            end
            ata_cmd_pkg::ST_XFER: begin
                if (hs & last_blk) begin
                    state_nxt = ata_cmd_pkg::ST_IDLE;
                end
            end
            default: state_nxt = ata_cmd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            avs_readdata <= 32'h00000000;
            state_r <= ata_cmd_pkg::ST_IDLE;
            completion_intrq <= 1'b0;
        end else if (ce) begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r) begin
                avs_readdata <= rd_mux;
            end
            state_r <= state_nxt;
            // Completion wins over a status read in the same cycle
            if (done_ev) begin
                completion_intrq <= 1'b1; // [RULE15] [RULE16]
            end else if (rd_ack & a_stat) begin
                completion_intrq <= 1'b0;
            end
        end
    end

    // Task file; native-max read returns the address in place
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            feat_r <= 8'h00;
            scnt_r <= 8'h00;
            snum_r <= 8'h00;
            cyll_r <= 8'h00;
            cylh_r <= 8'h00;
            drvh_r <= 8'h00;
            cmd_r <= 8'h00;
        end else if (ce) begin
            if (tf_wr & a_feat) feat_r <= avs_writedata[7:0];
            if (tf_wr & a_scnt) scnt_r <= avs_writedata[7:0];
            if (tf_wr & a_cmd) cmd_r <= avs_writedata[7:0];
            if (exec & is_nat) begin
                snum_r <= NATIVE_MAX[7:0];
                cyll_r <= NATIVE_MAX[15:8];
                cylh_r <= NATIVE_MAX[23:16];
                drvh_r <= {drvh_r[7:4], NATIVE_MAX[27:24]};
            end else begin
                if (tf_wr & a_snum) snum_r <= avs_writedata[7:0];
                if (tf_wr & a_cyll) cyll_r <= avs_writedata[7:0];
                if (tf_wr & a_cylh) cylh_r <= avs_writedata[7:0];
                if (tf_wr & a_drvh) drvh_r <= avs_writedata[7:0];
            end
        end
    end

    // Capacity limit, protection state and persistence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_r <= 1'b0;
            cur_max_r <= 28'h0000000;
            pass_r <= 28'h0000000;
            locked_r <= 1'b0;
            frozen_r <= 1'b0;
            nv_seen_r <= 1'b0;
            nv_max_out <= 28'h0000000;
            nv_max_we <= 1'b0;
        end else if (ce) begin
            nv_max_we <= 1'b0;
            if (!init_done_r) begin
                init_done_r <= 1'b1;
                cur_max_r <= nv_max_in; // [RULE5]
            end
            if (setmax_go & f9_plain) begin
                cur_max_r <= lba; // [RULE1]
                if (keep_over_reset_bit) begin
                    nv_max_out <= lba; // [RULE5]
                    nv_max_we <= 1'b1;
                    nv_seen_r <= 1'b1; // [RULE7]
                end
            end
            if (setmax_go & ~f9_plain) begin
                if (f9_pw) pass_r <= lba;
                if (f9_lock) locked_r <= 1'b1;
                if (f9_unlock) locked_r <= 1'b0;
                if (f9_freeze) frozen_r <= 1'b1; // [RULE6]
            end
        end
    end

    // Error, low power, multiple mode, monitoring hand-off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_r <= 1'b0;
            sleep_r <= 1'b0;
            mult_en_r <= 1'b0; // [RULE14]
            mult_r <= 8'h00;
            smart_req <= 1'b0;
            smart_feature <= 8'h00;
            smart_arg <= 8'h00;
        end else if (ce) begin
            smart_req <= 1'b0;
            if (cmd_take) begin
                sleep_r <= 1'b0; // [RULE17]
            end else if (exec) begin
                sleep_r <= is_low; // [RULE15] [RULE16]
                err_r <= abort_w; // [RULE12] [RULE20] [RULE22]
            end
            if (exec & is_setmult) begin
                mult_en_r <= mult_ok; // [RULE11] [RULE12] [RULE13]
                if (mult_ok) mult_r <= scnt_r; // [RULE11]
            end
            if (exec & is_smart & smart_ok) begin
                smart_req <= 1'b1;
                smart_feature <= feat_r;
                smart_arg <= scnt_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_r <= 9'h000;
            blk_len <= 9'h000;
            blk_is_write <= 1'b0;
        end else if (ce) begin
            if (exec & go_xfer) begin
                rem_r <= sc_total;
                blk_len <= first_len;
                blk_is_write <= is_wrm;
            end else if (hs) begin
                rem_r <= rem_left; // [RULE21]
                blk_len <= next_len;
            end
        end
    end

    assign low_power = sleep_r;

    busy_on_take_a: assert property (cmd_take |=> busy_flag ##1 !exec) // [RULE10]
        else $error("command not taken into busy");
    mult_store_a: assert property (exec && is_setmult && mult_ok
        |=> mult_en_r && mult_r == $past(scnt_r)) // [RULE11]
        else $error("valid block size not stored");
    mult_bad_a: assert property (exec && is_setmult && scnt_r != 8'h00
        && !mult_ok |=> err_r && !mult_en_r) // [RULE12]
        else $error("unsupported block size not aborted");
    mult_zero_a: assert property (exec && is_setmult && scnt_r == 8'h00
        |=> !mult_en_r && !err_r) // [RULE13]
        else $error("zero block size left multiple enabled");
    mult_reset_a: assert property (!init_done_r |-> !mult_en_r) // [RULE14]
        else $error("multiple enabled out of reset");
    sleep_enter_a: assert property (exec && is_sleep
        |=> sleep_r && !busy_flag && completion_intrq) // [RULE15]
        else $error("sleep not entered at once");
    stby_enter_a: assert property (exec && is_stby
        |=> sleep_r && !busy_flag && completion_intrq) // [RULE16]
        else $error("standby not entered at once");
    wake_cmd_a: assert property (sleep_r && cmd_take |=> !sleep_r) // [RULE17]
        else $error("low power not left on new command");
    dev_other_a: assert property (cmd_wr && !busy_flag && !dev_match
        |=> !busy_flag) // [RULE3]
        else $error("command for other device executed");
    max_set_a: assert property (setmax_go && f9_plain
        |=> cur_max_r == $past(lba)) // [RULE1]
        else $error("maximum not replaced");
    code_bad_a: assert property (exec && is_setmax && !f9_plain
        && f9_code_bad |=> err_r && $stable(cur_max_r)) // [RULE22]
        else $error("reserved subfunction accepted");
    nv_twice_a: assert property (exec && is_setmax && f9_plain
        && keep_over_reset_bit && nv_seen_r |=> err_r && !nv_max_we) // [RULE7]
        else $error("second nonvolatile limit accepted");
    wrm_off_a: assert property (exec && is_wrm && !mult_en_r
        |=> err_r && state_r == ata_cmd_pkg::ST_IDLE) // [RULE20]
        else $error("multiple write ran while disabled");
    blk_step_a: assert property (hs && !last_blk
        |=> rem_r == $past(rem_r) - $past(blk_len)
            && blk_len <= mult9 && blk_len != 9'h000) // [RULE21]
        else $error("block sequencing wrong");

    sleep_c: cover property (exec && is_sleep ##1 sleep_r);
    partial_c: cover property (hs && last_blk && blk_len < mult9);
    setmax_c: cover property (setmax_go && f9_plain && keep_over_reset_bit);
    smart_c: cover property (smart_req);
endmodule

// ### tb/ata_host_side_model.sv
/*
 Far side of the command block: nonvolatile maximum store and a
 block-descriptor consumer that stalls. Assumes one clock, no reset.
*/
module ata_host_side_model #(
    parameter logic [27:0] NV_INIT = 28'h0080000
) (
    input wire logic clk,
    input wire logic nv_max_we,
    input wire logic [27:0] nv_max_out,
    output logic [27:0] nv_max_in,
    output logic blk_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    initial nv_max_in = NV_INIT;
    initial blk_ready = 1'b0;
    // No reset: the stored maximum survives every device reset
    always @(posedge clk) if (nv_max_we === 1'b1) nv_max_in <= nv_max_out;
    // Accept one descriptor in three cycles
    always @(posedge clk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        blk_ready <= (ph == 2'h2);
    end
endmodule

// ### tb/ata_cmd_core_tb_top.sv
/*
 Testbench for the command block: Avalon register tasks, command
 sequences with expected values. Assumes device number 0, ce high.
*/
module ata_cmd_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, s;
    logic avs_waitrequest, nv_max_we, low_power, completion_intrq;
    logic blk_valid, blk_ready, blk_is_write, smart_req;
    logic [27:0] nv_max_in, nv_max_out;
    logic [8:0] blk_len;
    logic [7:0] smart_feature, smart_arg;
    logic [9:0] blks[$];
    int failures = 0, tests_run = 0, smart_cnt = 0;
    always #5 clk = ~clk;
    ata_cmd_core i_ata_cmd_core (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dev_strap(1'b0), .nv_max_in(nv_max_in), .nv_max_out(nv_max_out),
        .nv_max_we(nv_max_we), .low_power(low_power),
        .completion_intrq(completion_intrq), .blk_valid(blk_valid),
        .blk_ready(blk_ready), .blk_len(blk_len),
        .blk_is_write(blk_is_write), .smart_req(smart_req),
        .smart_feature(smart_feature), .smart_arg(smart_arg));
    ata_host_side_model i_ata_host_side_model (.clk(clk),
        .nv_max_we(nv_max_we), .nv_max_out(nv_max_out),
        .nv_max_in(nv_max_in), .blk_ready(blk_ready));
    always @(posedge clk) begin
        if ((blk_valid & blk_ready) === 1'b1)
            blks.push_back({blk_is_write, blk_len});
        if (smart_req === 1'b1) smart_cnt++;
    end
    task final_report;
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            failures++;
        end
    endtask
    task acc(input logic [5:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        s = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            failures++;
            final_report;
        end
    endtask
    task tf(input logic [7:0] v[6]);
        for (int i = 0; i < 6; i++)
            acc(ata_cmd_pkg::OFS_FEAT + 6'(i * 4), 1'b1, v[i]);
    endtask
    // Issue a command, then poll status until busy clears
    task cmd(input logic [7:0] op);
        int n;
        acc(ata_cmd_pkg::OFS_CMD, 1'b1, op);
        n = 0;
        do begin
            acc(ata_cmd_pkg::OFS_STAT, 1'b0, 8'h00);
            n++;
        end while (s[7] !== 1'b0 && n < 300);
        if (n >= 300) begin
            failures++;
            final_report;
        end
    endtask
    task rst;
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // Native read directly before the limit, LBA bit set
    task smax(input logic [27:0] a, input logic [7:0] sc, f, input logic dv);
        acc(ata_cmd_pkg::OFS_DRVH, 1'b1, 8'h40);
        cmd(ata_cmd_pkg::OP_NATIVE);
        tf('{f, sc, a[7:0], a[15:8], a[23:16], {3'h2, dv, a[27:24]}});
        cmd(ata_cmd_pkg::OP_SETMAX);
    endtask
    task mx(input logic [27:0] e);
        acc(ata_cmd_pkg::OFS_MAX, 1'b0, 8'h00);
        chk(s, {4'h0, e});
    endtask
    // Block size bs as programmed, zero when the command must abort
    task xfer(input logic [7:0] op, sc, input logic w, input logic [7:0] bs);
        blks.delete();
        tf('{8'h00, sc, 8'h00, 8'h00, 8'h00, 8'h40});
        cmd(op);
        for (int i = 0; bs > 0 && i < sc; i += bs)
            chk(blks.pop_front(), {w, 9'((sc - i > bs) ? bs : sc - i)});
        chk(blks.size(), 0);
    endtask
    logic [7:0] mt[5] = '{8'h10, 8'h03, 8'h11, 8'h00, 8'h04};
    logic [1:0] me[5] = '{2'b10, 2'b01, 2'b01, 2'b00, 2'b10};
    logic [7:0] sl[4] = '{8'h99, 8'he6, 8'h96, 8'he2};
    logic [7:0] rf[3] = '{8'h00, 8'h05, 8'hff};
    initial begin
        rst;
        acc(ata_cmd_pkg::OFS_STAT, 1'b0, 8'h00);
        chk(s[ata_cmd_pkg::SB_MULT], 0);
        acc(ata_cmd_pkg::OFS_IDW82, 1'b0, 8'h00);
        chk(s, {16'h0, ata_cmd_pkg::IDW82_VAL});
        mx(28'h0080000);
        xfer(ata_cmd_pkg::OP_WRMULT, 8'h0a, 1'b1, 8'h00);
        chk(s[ata_cmd_pkg::SB_ERR], 1);
        for (int i = 0; i < 5; i++) begin
            tf('{8'h00, mt[i], 8'h00, 8'h00, 8'h00, 8'h40});
            cmd(ata_cmd_pkg::OP_SETMULT);
            chk(s[ata_cmd_pkg::SB_MULT], me[i][1]);
            chk(s[ata_cmd_pkg::SB_ERR], me[i][0]);
        end
        acc(ata_cmd_pkg::OFS_MULT, 1'b0, 8'h00);
        chk(s, 32'h4);
        xfer(ata_cmd_pkg::OP_WRMULT, 8'h0a, 1'b1, 8'h04);
        xfer(ata_cmd_pkg::OP_RDMULT, 8'h05, 1'b0, 8'h04);
        for (int i = 0; i < 4; i++) begin
            acc(ata_cmd_pkg::OFS_CMD, 1'b1, sl[i]);
            repeat (2) @(posedge clk);
            chk(completion_intrq, 1);
            chk(low_power, 1);
            cmd(ata_cmd_pkg::OP_NATIVE);
            chk(low_power, 0);
        end
        tf('{8'hd8, 8'h01, 8'h00, 8'h4f, 8'hc2, 8'he0});
        cmd(ata_cmd_pkg::OP_SMART);
        chk({s[0], smart_feature, smart_arg}, {1'b0, 16'hd801});
        tf('{8'hd8, 8'h01, 8'h00, 8'h4f, 8'hc3, 8'he0});
        cmd(ata_cmd_pkg::OP_SMART);
        chk({s[0], 8'(smart_cnt)}, {1'b1, 8'h01});
        // Boot flow: limit to native, then to the file-system size
        smax(28'h0100000, 8'h00, 8'h00, 1'b0);
        smax(28'h0012345, 8'h00, 8'h00, 1'b0);
        mx(28'h0012345);
        smax(28'h0000777, 8'h00, 8'h00, 1'b1);
        mx(28'h0012345);
        for (int i = 0; i < 3; i++) begin
            smax(28'h0000555, 8'h02, rf[i], 1'b0);
            chk(s[0], 1);
            mx(28'h0012345);
        end
        // Password, lock, wrong and right unlock, freeze blocks a lock
        smax(28'h0000abc, 8'h02, 8'h01, 1'b0);
        smax(28'h0000000, 8'h02, 8'h02, 1'b0);
        chk(s[ata_cmd_pkg::SB_LOCK], 1);
        smax(28'h0000400, 8'h00, 8'h00, 1'b0);
        chk(s[0], 1);
        smax(28'h0000111, 8'h02, 8'h03, 1'b0);
        chk({s[ata_cmd_pkg::SB_LOCK], s[0]}, 2'b11);
        smax(28'h0000abc, 8'h02, 8'h03, 1'b0);
        chk({s[ata_cmd_pkg::SB_LOCK], s[0]}, 2'b00);
        smax(28'h0000000, 8'h02, 8'h04, 1'b0);
        smax(28'h0000000, 8'h02, 8'h02, 1'b0);
        chk({s[ata_cmd_pkg::SB_FRZ], s[0]}, 2'b11);
        mx(28'h0012345);
        smax(28'h0002000, 8'h01, 8'h00, 1'b0);
        chk(nv_max_in, 28'h0002000);
        smax(28'h0003000, 8'h01, 8'h00, 1'b0);
        chk(s[0], 1);
        // Shutdown flow: volatile limit, then reset reverts it
        smax(28'h0000300, 8'h00, 8'h00, 1'b0);
        mx(28'h0000300);
        rst;
        mx(28'h0002000);
        final_report;
    end
endmodule
